//--- logic/sdram_cmd_pkg.sv
// shared constants for the sdram command layer
package sdram_cmd_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int BANKS = 4;
    localparam int MODE_W = 13;
    // mode register field positions, then the auto precharge address bit
    localparam int MR_BL_LO = 0;
    localparam int MR_BL_HI = 2;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LO = 4;
    localparam int MR_CL_HI = 6;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int MR_WR_LO = 9;
    localparam int MR_WR_HI = 11;
    localparam int EMR1_DLL_BIT = 0;
    localparam int AP_BIT = 10;
    // burst length encodings
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;
    // register select on bank lines
    localparam logic [1:0] SEL_MR = 2'h0;
    localparam logic [1:0] SEL_EMR1 = 2'h1;
    localparam logic [1:0] SEL_EMR2 = 2'h2;
    localparam logic [1:0] SEL_EMR3 = 2'h3;
    localparam logic [MODE_W-1:0] ZERO_MODE = 13'h0000;
    localparam logic [ROW_W-1:0] ZERO_ROW = 13'h0000;
    localparam logic [COL_W-1:0] ZERO_COL = 10'h000;
    localparam logic [3:0] ZERO_BEAT = 4'h0;
    localparam logic [BANKS-1:0] ALL_BANKS = 4'hf;
    localparam logic [BANKS-1:0] NO_BANKS = 4'h0;
    localparam logic [2:0] ZERO_CL = 3'h0;
    localparam logic [3:0] ONE_BEAT = 4'h1;

    typedef enum logic [2:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_MODE, CMD_REF
    } cmd_e;

    typedef enum {PWR_ACTIVE, PWR_DOWN, PWR_SELF_REF} pwr_e;
endpackage

//--- logic/sdram_cmd_core.sv
// command decode, bank state, mode registers and burst sequencing
// How it works
// - activate opens row from address lines in selected bank
// - precharge closes all banks with address ten high, else one bank
// - column command: write strobe picks read or write; line ten auto precharge
// - each access is a burst of four or eight beats in programmed order
// - activate only to idle bank, column only to active bank, mode and refresh when all idle
// - clock enable old and new levels select self refresh, power down, exit
// - byte masks high discard that byte lane of write data independently
// - mode write uses all strobes low, bank lines pick register, address holds data
// - mode register may be rewritten later while all banks are precharged
// - mode bits two to zero give burst length
// - mode bit three picks sequential or interleaved order for both lengths
// - mode bits six to four give read latency in clocks
// - bank lines select main, extended one, two or three register
// - extended one bit zero low enables the delay locked loop
`timescale 1ns/1ps

module sdram_cmd_core #(
    parameter int ROW_W = sdram_cmd_pkg::ROW_W,
    parameter int COL_W = sdram_cmd_pkg::COL_W
) (
    // system
    input wire logic clk,
    input wire logic arst_n,
    // memory clock and command pins
    input wire logic mem_clk,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_0,
    input wire logic bank_select_1,
    input wire logic [12:0] addr,
    // write data, masks and termination
    input wire logic [15:0] wr_data,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic die_termination_control,
    // array side beats
    output logic beat_valid,
    output logic beat_write,
    output logic [1:0] beat_bank,
    output logic [ROW_W-1:0] beat_row,
    output logic [COL_W-1:0] beat_col,
    output logic [15:0] beat_data,
    output logic [1:0] beat_lane_en,
    // status
    output logic [3:0] bank_open,
    output logic [12:0] operating_mode_register,
    output logic dll_enabled,
    output logic self_refresh,
    output logic power_down,
    output logic refresh_pulse,
    output logic auto_precharge_pend,
    output logic illegal_cmd
);
    typedef struct packed {
        logic [1:0] clk_sync;
        logic clk_prev;
        logic [21:0] pin_s1;
        logic [21:0] pin_s2;
        logic [15:0] data_s1;
        logic [15:0] data_s2;
        logic cke_prev;
        logic [3:0] open;
        logic [3:0][ROW_W-1:0] row;
        logic [12:0] mr;
        logic [12:0] emr1;
        logic [12:0] emr2;
        logic [12:0] emr3;
        logic [1:0] pwr;
        logic [3:0] beats_left;
        logic [3:0] beat_idx;
        logic bwrite;
        logic bauto;
        logic [1:0] bbank;
        logic [COL_W-1:0] bstart;
        logic [2:0] wr_wait;
        logic [2:0] lat_left;
        logic bv;
        logic bw;
        logic [1:0] bb;
        logic [ROW_W-1:0] br;
        logic [COL_W-1:0] bc;
        logic [15:0] bd;
        logic [1:0] ble;
        logic refp;
        logic ill;
    } state_s;

    state_s st_reg, st_next;

    // local names for the package command and power codes
    localparam sdram_cmd_pkg::cmd_e CMD_DESEL = sdram_cmd_pkg::CMD_DESEL;
    localparam sdram_cmd_pkg::cmd_e CMD_NOP = sdram_cmd_pkg::CMD_NOP;
    localparam sdram_cmd_pkg::cmd_e CMD_ACT = sdram_cmd_pkg::CMD_ACT;
    localparam sdram_cmd_pkg::cmd_e CMD_PRE = sdram_cmd_pkg::CMD_PRE;
    localparam sdram_cmd_pkg::cmd_e CMD_RD = sdram_cmd_pkg::CMD_RD;
    localparam sdram_cmd_pkg::cmd_e CMD_WR = sdram_cmd_pkg::CMD_WR;
    localparam sdram_cmd_pkg::cmd_e CMD_MODE = sdram_cmd_pkg::CMD_MODE;
    localparam sdram_cmd_pkg::cmd_e CMD_REF = sdram_cmd_pkg::CMD_REF;
    localparam sdram_cmd_pkg::pwr_e PWR_ACTIVE = sdram_cmd_pkg::PWR_ACTIVE;
    localparam sdram_cmd_pkg::pwr_e PWR_DOWN = sdram_cmd_pkg::PWR_DOWN;
    localparam sdram_cmd_pkg::pwr_e PWR_SELF_REF = sdram_cmd_pkg::PWR_SELF_REF;

    // sequence of burst address within the wrap group
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                   input logic [3:0] idx,
                                                   input logic eight,
                                                   input logic ileave);
        logic [2:0] low;
        logic [2:0] s;
        s = start[2:0];
        if (ileave) begin
            low = s ^ idx[2:0];
        end else begin
            low = s + idx[2:0];
        end
        if (!eight) begin
            low[2] = s[2];
        end
        return {start[COL_W-1:3], low};
    endfunction

    sdram_cmd_pkg::cmd_e cmd;
    logic edge_seen;
    logic cke_now;
    logic [1:0] ba;
    logic [12:0] a_s;
    logic all_idle;
    logic [3:0] bl_beats;

    always_comb begin
        edge_seen = st_reg.clk_sync[1] & ~st_reg.clk_prev;
        cke_now = st_reg.pin_s2[21];
        ba = st_reg.pin_s2[16:15];
        a_s = st_reg.pin_s2[14:2];
        all_idle = (st_reg.open == sdram_cmd_pkg::NO_BANKS);
        bl_beats = (st_reg.mr[sdram_cmd_pkg::MR_BL_HI:sdram_cmd_pkg::MR_BL_LO]
                    == sdram_cmd_pkg::BL_8) ? sdram_cmd_pkg::BEATS_8 : sdram_cmd_pkg::BEATS_4;
        if (st_reg.pin_s2[20]) begin
            cmd = CMD_DESEL;
        end else begin
            case (st_reg.pin_s2[19:17])
                3'b111: cmd = CMD_NOP;
                3'b011: cmd = CMD_ACT;
                3'b010: cmd = CMD_PRE;
                3'b101: cmd = CMD_RD;
                3'b100: cmd = CMD_WR;
                3'b000: cmd = CMD_MODE;
                3'b001: cmd = CMD_REF;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.clk_sync = {st_reg.clk_sync[0], mem_clk};
        st_next.clk_prev = st_reg.clk_sync[1];
        st_next.pin_s1 = {cke, cs_n, ras_n, cas_n, we_n, bank_select_1, bank_select_0, addr,
                          upper_byte_mask, lower_byte_mask};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.data_s1 = wr_data;
        st_next.data_s2 = st_reg.data_s1;
        st_next.refp = 1'b0;
        st_next.bv = 1'b0;
        if (edge_seen) begin
            st_next.cke_prev = cke_now;
            st_next.ill = 1'b0;
            if (st_reg.pwr != 2'(PWR_ACTIVE)) begin
                if (!st_reg.cke_prev && cke_now && (cmd == CMD_DESEL || cmd == CMD_NOP)) begin
                    st_next.pwr = 2'(PWR_ACTIVE);
                end
            end else if (st_reg.cke_prev && !cke_now) begin
                if (cmd == CMD_REF && all_idle) begin
                    st_next.pwr = 2'(PWR_SELF_REF);
                end else if (cmd == CMD_DESEL || cmd == CMD_NOP) begin
                    st_next.pwr = 2'(PWR_DOWN);
                end
            end else if (st_reg.cke_prev && cke_now) begin
                case (cmd)
                    CMD_ACT: begin
                        if (!st_reg.open[ba]) begin
                            st_next.open[ba] = 1'b1;
                            st_next.row[ba] = a_s[ROW_W-1:0];
                        end else begin
                            st_next.ill = 1'b1;
                        end
                    end
                    CMD_PRE: begin
                        if (a_s[sdram_cmd_pkg::AP_BIT]) begin
                            st_next.open = sdram_cmd_pkg::NO_BANKS;
                        end else begin
                            st_next.open[ba] = 1'b0;
                        end
                    end
                    CMD_RD, CMD_WR: begin
                        if (st_reg.open[ba] && st_reg.beats_left == sdram_cmd_pkg::ZERO_BEAT) begin
                            st_next.bwrite = (cmd == CMD_WR);
                            st_next.bauto = a_s[sdram_cmd_pkg::AP_BIT];
                            st_next.bbank = ba;
                            st_next.bstart = a_s[COL_W-1:0];
                            st_next.beats_left = bl_beats;
                            st_next.beat_idx = sdram_cmd_pkg::ZERO_BEAT;
                            st_next.lat_left = (cmd == CMD_RD) ?
                                st_reg.mr[sdram_cmd_pkg::MR_CL_HI:sdram_cmd_pkg::MR_CL_LO] : 3'h1;
                        end else begin
                            st_next.ill = 1'b1;
                        end
                    end
                    CMD_MODE: begin
                        if (all_idle) begin
                            case (ba)
                                sdram_cmd_pkg::SEL_MR: st_next.mr = a_s;
                                sdram_cmd_pkg::SEL_EMR1: st_next.emr1 = a_s;
                                sdram_cmd_pkg::SEL_EMR2: st_next.emr2 = a_s;
                                default: st_next.emr3 = a_s;
                            endcase
                        end else begin
                            st_next.ill = 1'b1;
                        end
                    end
                    CMD_REF: begin
                        if (all_idle) begin
                            st_next.refp = 1'b1;
                        end else begin
                            st_next.ill = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // burst beat stepping, one beat per edge once read latency has run
            if (st_reg.beats_left != sdram_cmd_pkg::ZERO_BEAT && st_reg.lat_left > 3'h1) begin
                st_next.lat_left = st_reg.lat_left - 3'h1;
            end else if (st_reg.beats_left != sdram_cmd_pkg::ZERO_BEAT) begin
                st_next.bv = 1'b1;
                st_next.bw = st_reg.bwrite;
                st_next.bb = st_reg.bbank;
                st_next.br = st_reg.row[st_reg.bbank];
                st_next.bc = burst_col(st_reg.bstart, st_reg.beat_idx,
                                       st_reg.mr[sdram_cmd_pkg::MR_BL_HI:sdram_cmd_pkg::MR_BL_LO]
                                       == sdram_cmd_pkg::BL_8,
                                       st_reg.mr[sdram_cmd_pkg::MR_BT_BIT]);
                st_next.bd = st_reg.data_s2;
                st_next.ble = st_reg.bwrite ? ~st_reg.pin_s2[1:0] : 2'b11;
                st_next.beats_left = st_reg.beats_left - sdram_cmd_pkg::ONE_BEAT;
                st_next.beat_idx = st_reg.beat_idx + sdram_cmd_pkg::ONE_BEAT;
                if (st_reg.beats_left == sdram_cmd_pkg::ONE_BEAT && st_reg.bauto) begin
                    st_next.wr_wait = st_reg.bwrite ?
                        st_reg.mr[sdram_cmd_pkg::MR_WR_HI:sdram_cmd_pkg::MR_WR_LO] : 3'h1;
                end
            end else if (st_reg.wr_wait != 3'h0) begin
                st_next.wr_wait = st_reg.wr_wait - 3'h1;
                if (st_reg.wr_wait == 3'h1) begin
                    st_next.open[st_reg.bbank] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        beat_valid = st_reg.bv;
        beat_write = st_reg.bw;
        beat_bank = st_reg.bb;
        beat_row = st_reg.br;
        beat_col = st_reg.bc;
        beat_data = st_reg.bd;
        beat_lane_en = st_reg.ble;
        bank_open = st_reg.open;
        operating_mode_register = st_reg.mr;
        dll_enabled = ~st_reg.emr1[sdram_cmd_pkg::EMR1_DLL_BIT];
        self_refresh = (st_reg.pwr == 2'(PWR_SELF_REF));
        power_down = (st_reg.pwr == 2'(PWR_DOWN));
        refresh_pulse = st_reg.refp;
        auto_precharge_pend = (st_reg.wr_wait != 3'h0);
        illegal_cmd = st_reg.ill;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_act_opens;
        @(posedge clk) disable iff (!arst_n)
        (edge_seen && cke_now && st_reg.cke_prev && cmd == CMD_ACT && !st_reg.open[ba])
            |=> st_reg.open[$past(ba)];
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate did not open bank");

    property p_pre_all;
        @(posedge clk) disable iff (!arst_n)
        (edge_seen && cke_now && st_reg.cke_prev && cmd == CMD_PRE && a_s[10])
            |=> st_reg.open == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left bank open");

    property p_burst_len;
        @(posedge clk) disable iff (!arst_n)
        $rose(st_reg.beats_left != 4'h0) |-> st_reg.beats_left == bl_beats;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

    property p_no_act_open;
        @(posedge clk) disable iff (!arst_n)
        (edge_seen && cke_now && st_reg.cke_prev && cmd == CMD_ACT && st_reg.open[ba])
            |=> illegal_cmd;
    endproperty
    a_no_act_open: assert property (p_no_act_open) else $error("activate to open bank taken");

    property p_self_ref;
        @(posedge clk) disable iff (!arst_n)
        (edge_seen && st_reg.pwr == 2'(PWR_ACTIVE) && st_reg.cke_prev && !cke_now
            && cmd == CMD_REF && all_idle) |=> self_refresh;
    endproperty
    a_self_ref: assert property (p_self_ref) else $error("self refresh not entered");

    property p_mask;
        @(posedge clk) disable iff (!arst_n)
        beat_valid && beat_write |-> beat_lane_en == ~$past(st_reg.pin_s2[1:0], 1);
    endproperty
    a_mask: assert property (p_mask) else $error("byte mask not applied");

    property p_mode_write;
        @(posedge clk) disable iff (!arst_n)
        (edge_seen && cke_now && st_reg.cke_prev && cmd == CMD_MODE && all_idle && ba == 2'h0)
            |=> operating_mode_register == $past(a_s);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode register not written");

    property p_ref_busy;
        @(posedge clk) disable iff (!arst_n)
        refresh_pulse |-> $past(all_idle);
    endproperty
    a_ref_busy: assert property (p_ref_busy) else $error("refresh with open bank");

    c_burst8: cover property (@(posedge clk) disable iff (!arst_n) st_reg.beats_left == 4'h8);
    c_self: cover property (@(posedge clk) disable iff (!arst_n) self_refresh);
    c_ap: cover property (@(posedge clk) disable iff (!arst_n) $fell(auto_precharge_pend));
endmodule // sdram_cmd_core

//--- tb/mem_ctrl_model.sv
// memory controller model driving commands, write data and masks
`timescale 1ns/1ps

module mem_ctrl_model #(
    parameter int PWRUP_EDGES = 1600,
    parameter int MRD_EDGES = 2,
    parameter int DLL_LOCK_EDGES = 200
) (
    // system
    input wire logic clk,
    // memory clock and command pins
    output logic mem_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select_0,
    output logic bank_select_1,
    output logic [12:0] addr,
    // write data, masks and termination
    output logic [15:0] wr_data,
    output logic lower_byte_mask,
    output logic upper_byte_mask,
    output logic die_termination_control
);
    localparam logic [3:0] C_NOP = 4'h7;
    logic [15:0] beat_dat [8];
    logic [1:0] beat_msk [8];
    // termination may move freely once initialization is over
    bit term_free = 1'b0;

    // ----------------------------------------
    // free running memory clock
    // ----------------------------------------
    initial begin
        {mem_clk, cke, die_termination_control} = 3'b000;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        {bank_select_1, bank_select_0} = 2'h0;
        addr = 13'h0000;
        wr_data = 16'h5a5a;
        {upper_byte_mask, lower_byte_mask} = 2'h0;
        #17;
        forever #62.5 mem_clk = ~mem_clk;
    end

    // ----------------------------------------
    // command tasks
    // ----------------------------------------
    // pins change mid cycle so the rising edge sees them settled
    task automatic drive(input logic ck, input logic [3:0] c, input logic [1:0] ba,
                         input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
        @(negedge mem_clk);
        @(posedge clk);
        cke <= ck;
        {cs_n, ras_n, cas_n, we_n} <= c;
        {bank_select_1, bank_select_0} <= ba;
        addr <= a;
        wr_data <= d;
        {upper_byte_mask, lower_byte_mask} <= m;
        die_termination_control <= term_free & 1'($urandom);
    endtask
    // data and masks outside a write beat carry no stale value
    task automatic cmd(input logic ck, input logic [3:0] c, input logic [1:0] ba,
                       input logic [12:0] a);
        drive(ck, c, ba, a, ~wr_data, ~{upper_byte_mask, lower_byte_mask});
    endtask
    task automatic nop(input int n);
        repeat (n) cmd(1'b1, C_NOP, 2'h0, 13'h0000);
    endtask
    task automatic mode(input logic [1:0] sel, input logic [12:0] v);
        cmd(1'b1, 4'h0, sel, v);
        nop(MRD_EDGES);
    endtask
    task automatic col(input logic wr, input logic [1:0] ba, input logic [9:0] c,
                       input logic ap, input int bl);
        cmd(1'b1, {3'b010, ~wr}, ba, {2'b00, ap, c});
        for (int i = 0; i < bl; i++) begin
            drive(1'b1, C_NOP, 2'h0, 13'h0000, beat_dat[i], beat_msk[i]);
        end
        nop(2);
    endtask
    task automatic init_seq(input logic [12:0] mr_val);
        repeat (PWRUP_EDGES) cmd(1'b0, C_NOP, 2'h0, 13'h0000);
        nop(4);
        cmd(1'b1, 4'h2, 2'h0, 13'h0400);
        nop(2);
        mode(2'h2, 13'h0000);
        mode(2'h3, 13'h0000);
        mode(2'h1, 13'h0000);
        mode(2'h0, mr_val | 13'h0100);
        cmd(1'b1, 4'h2, 2'h0, 13'h0400);
        nop(2);
        repeat (2) begin
            cmd(1'b1, 4'h1, 2'h0, 13'h0000);
            nop(2);
        end
        mode(2'h0, mr_val);
        mode(2'h1, 13'h0380);
        mode(2'h1, 13'h0000);
        nop(DLL_LOCK_EDGES);
    endtask
endmodule // mem_ctrl_model

//--- tb/ddr2_command_init_mode_logic_tb.sv
// self-checking bench for the sdram command layer
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end

module ddr2_command_init_mode_logic_tb;
    localparam logic [2:0] WR_FIELD = 3'h4;
    localparam logic [2:0] CL_FIELD = 3'h3;
    typedef struct packed {
        logic wr;
        logic [1:0] bank;
        logic [12:0] row;
        logic [9:0] col;
        logic [15:0] data;
        logic [1:0] lane;
    } beat_s;
    logic clk, arst_n, mem_clk, cke, cs_n, ras_n, cas_n, we_n;
    logic bank_select_0, bank_select_1, lower_byte_mask, upper_byte_mask;
    logic die_termination_control, beat_valid, beat_write, dll_enabled;
    logic self_refresh, power_down, refresh_pulse, auto_precharge_pend, illegal_cmd;
    logic [12:0] addr, operating_mode_register, mr;
    logic [15:0] wr_data, beat_data, lm;
    logic [1:0] beat_bank, beat_lane_en, ba;
    logic [12:0] beat_row;
    logic [9:0] beat_col;
    logic [3:0] bank_open, exp_open;
    logic [12:0] rows [4];
    beat_s exp_q[$];
    beat_s eb;
    int error_cnt = 0;
    int comparisons = 0;
    int ref_cnt = 0;
    int unsigned seed;

    sdram_cmd_core u_dut (
        .clk(clk), .arst_n(arst_n), .mem_clk(mem_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_0(bank_select_0),
        .bank_select_1(bank_select_1), .addr(addr), .wr_data(wr_data),
        .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
        .die_termination_control(die_termination_control), .beat_valid(beat_valid),
        .beat_write(beat_write), .beat_bank(beat_bank), .beat_row(beat_row),
        .beat_col(beat_col), .beat_data(beat_data), .beat_lane_en(beat_lane_en),
        .bank_open(bank_open), .operating_mode_register(operating_mode_register),
        .dll_enabled(dll_enabled), .self_refresh(self_refresh), .power_down(power_down),
        .refresh_pulse(refresh_pulse), .auto_precharge_pend(auto_precharge_pend),
        .illegal_cmd(illegal_cmd)
    );
    mem_ctrl_model u_ctrl (
        .clk(clk), .mem_clk(mem_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_select_0(bank_select_0),
        .bank_select_1(bank_select_1), .addr(addr), .wr_data(wr_data),
        .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
        .die_termination_control(die_termination_control)
    );

    always #5 clk = ~clk;

    // ----------------------------------------
    // reference model and beat checks
    // ----------------------------------------
    function automatic logic [12:0] mode_val(input logic bl8, input logic ilv);
        return {1'b0, WR_FIELD, 2'b00, CL_FIELD, ilv,
                bl8 ? sdram_cmd_pkg::BL_8 : sdram_cmd_pkg::BL_4};
    endfunction
    task automatic activate(input logic [1:0] b, input logic [12:0] r);
        u_ctrl.cmd(1'b1, 4'h3, b, r);
        u_ctrl.nop(1);
        rows[b] = r;
        exp_open[b] = 1'b1;
        `CHK("bank_open", exp_open, bank_open)
    endtask
    task automatic precharge(input logic [1:0] b, input logic all);
        u_ctrl.cmd(1'b1, 4'h2, b, {2'b00, all, 10'h000});
        u_ctrl.nop(1);
        if (all) exp_open = 4'h0;
        else exp_open[b] = 1'b0;
        `CHK("bank_open", exp_open, bank_open)
    endtask
    task automatic column(input logic wr, input logic [1:0] b, input logic [9:0] c,
                          input logic ap, input logic bl8, input logic ilv);
        beat_s x;
        logic [2:0] k;
        logic [2:0] wrap;
        wrap = bl8 ? 3'h7 : 3'h3;
        for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
            k = ilv ? (c[2:0] ^ 3'(i)) : (c[2:0] + 3'(i));
            x.wr = wr;
            x.bank = b;
            x.row = rows[b];
            x.col = {c[9:3], (c[2:0] & ~wrap) | (k & wrap)};
            x.data = 16'($urandom);
            x.lane = 2'($urandom);
            u_ctrl.beat_dat[i] = x.data;
            u_ctrl.beat_msk[i] = x.lane;
            x.lane = ~x.lane;
            exp_q.push_back(x);
        end
        u_ctrl.col(wr, b, c, ap, bl8 ? 8 : 4);
    endtask
    task automatic final_report();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (refresh_pulse === 1'b1) ref_cnt++;
        if (beat_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("beat_extra", 1'b0, 1'b1)
            end else begin
                eb = exp_q.pop_front();
                lm = {{8{eb.lane[1]}}, {8{eb.lane[0]}}};
                `CHK("beat_write", eb.wr, beat_write)
                `CHK("beat_bank", eb.bank, beat_bank)
                `CHK("beat_row", eb.row, beat_row)
                `CHK("beat_col", eb.col, beat_col)
                if (eb.wr) begin
                    `CHK("beat_lane_en", eb.lane, beat_lane_en)
                    `CHK("beat_data", eb.data & lm, beat_data & lm)
                end
            end
        end
    end

    initial begin
        #800us;
        error_cnt++;
        final_report();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        seed = $urandom(83);
        clk = 1'b0;
        arst_n = 1'b0;
        exp_open = 4'h0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        `CHK("bank_open", 4'h0, bank_open)
        `CHK("mode_reg", 13'h0000, operating_mode_register)
        mr = mode_val(1'b1, 1'b0);
        u_ctrl.init_seq(mr);
        u_ctrl.term_free = 1'b1;
        `CHK("mode_reg", mr, operating_mode_register)
        `CHK("dll_enabled", 1'b1, dll_enabled)
        `CHK("refresh_count", 2, ref_cnt)
        for (int cfg = 0; cfg < 4; cfg++) begin
            mr = mode_val(cfg[1], cfg[0]);
            u_ctrl.mode(2'h0, mr);
            `CHK("mode_reg", mr, operating_mode_register)
            ba = 2'($urandom);
            activate(ba, 13'($urandom));
            column(1'b1, ba, 10'($urandom), 1'b0, cfg[1], cfg[0]);
            column(1'b0, ba, 10'($urandom), 1'b0, cfg[1], cfg[0]);
            precharge(ba, 1'b0);
        end
        activate(2'h1, 13'h0123);
        u_ctrl.cmd(1'b1, 4'h3, 2'h1, 13'h0456);
        u_ctrl.nop(1);
        `CHK("illegal_cmd", 1'b1, illegal_cmd)
        u_ctrl.cmd(1'b1, 4'h0, 2'h0, 13'h0000);
        u_ctrl.nop(1);
        `CHK("mode_reg", mr, operating_mode_register)
        u_ctrl.cmd(1'b1, 4'h1, 2'h0, 13'h0000);
        u_ctrl.nop(1);
        `CHK("refresh_count", 2, ref_cnt)
        u_ctrl.cmd(1'b1, {1'b1, 3'($urandom)}, 2'($urandom), 13'($urandom));
        u_ctrl.nop(1);
        `CHK("bank_open", exp_open, bank_open)
        `CHK("illegal_cmd", 1'b0, illegal_cmd)
        activate(2'h2, 13'h1fff);
        precharge(2'h0, 1'b1);
        u_ctrl.cmd(1'b1, 4'h5, 2'h2, 13'h0000);
        u_ctrl.nop(1);
        `CHK("illegal_cmd", 1'b1, illegal_cmd)
        for (int w = 0; w < 2; w++) begin
            activate(2'h3, 13'($urandom));
            column(w[0], 2'h3, 10'($urandom), 1'b1, 1'b1, 1'b1);
            // bank stays open until the edge after read latency or write recovery
            u_ctrl.nop((w == 1) ? int'(WR_FIELD) - 2 : int'(CL_FIELD) - 2);
            `CHK("bank_open", exp_open, bank_open)
            u_ctrl.nop(1);
            exp_open[3] = 1'b0;
            `CHK("bank_open", exp_open, bank_open)
        end
        u_ctrl.cmd(1'b0, 4'h7, 2'h0, 13'h0000);
        u_ctrl.cmd(1'b0, 4'h7, 2'h0, 13'h0000);
        `CHK("power_down", 1'b1, power_down)
        u_ctrl.cmd(1'b1, 4'h7, 2'h0, 13'h0000);
        u_ctrl.nop(1);
        `CHK("power_down", 1'b0, power_down)
        u_ctrl.cmd(1'b0, 4'h1, 2'h0, 13'h0000);
        u_ctrl.cmd(1'b0, 4'h7, 2'h0, 13'h0000);
        `CHK("self_refresh", 1'b1, self_refresh)
        u_ctrl.cmd(1'b1, 4'h7, 2'h0, 13'h0000);
        u_ctrl.nop(1);
        `CHK("self_refresh", 1'b0, self_refresh)
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk);
        `CHK("beats_left", 0, exp_q.size())
        final_report();
    end
endmodule // ddr2_command_init_mode_logic_tb
